// ### rtl/cplc_pkg.sv
package cplc_pkg;

  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int READSEL_POS = 13;
  localparam int NOWRITE_POS = 12;
  localparam int SUPPLY_POS = 11;
  localparam int PN_POS = 10;
  localparam int TIMEOUT_POS = 9;
  localparam int TXDIS_POS = 8;
  localparam int LOOP_POS = 7;
  localparam int ACTIVE_POS = 6;
  localparam int FIELD_LO = 6;
  localparam int FIELD_HI = 11;
  localparam int FIELD_W = 6;

  localparam logic [1:0] PHY_CTRL_ADDR = 2'h3;
  // Bits received before the reply word can be chosen
  localparam logic [4:0] SELECT_BITS = 5'h03;
  localparam logic [4:0] FULL_FRAME = 5'h10;
  localparam logic [4:0] COUNT_MAX = 5'h1F;

  // Reset values
  localparam logic [5:0] FIELDS_RESET = 6'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Synchronisers reset to the idle pin levels
  localparam logic [2:0] SPI_SYNC_RESET = 3'h4;
  localparam logic [1:0] LOOP_SYNC_RESET = 2'h3;

  typedef enum logic [1:0] {
    CPLC_TO_SHORT,
    CPLC_TO_LONG,
    CPLC_TO_EXTENDED
  } cplc_timeout_t;

  typedef enum logic {
    CPLC_IDLE,
    CPLC_SHIFT
  } cplc_frame_t;

endpackage

// ### rtl/cplc_regs.sv
`timescale 1ns/100ps
// Operation
// - Frame top bits 11 address this register
// - Bit 13 picks feedback one or readback
// - Read-only bit set: no store
// - Read-only bit clear: reply and store
// - Bit 11 keeps supply on off-line
// - Partial networking: listen-only instead of normal
// - Normal on-line or active entry clears partial
// - Bit 9 long/short timeout, wake extends
// - Bit 8 disables the transmitter
// - Bit 7 with bit 8 loops transmit back
// - Active request honoured in normal/flash only
// - Bit 8 clear enables the transmitter
// - Bit 7 clear: no loopback
module cplc_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  input wire logic spi_csn,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic [15:0] gp_feedback_one,
  input wire logic can_txd_in,
  input wire logic can_bus_rxd,
  output logic can_rxd_out,
  input wire logic offline_mode,
  input wire logic enter_online_normal,
  input wire logic enter_can_active,
  input wire logic wake_event,
  input wire logic chip_normal_mode,
  input wire logic chip_flash_mode,
  output logic transceiver_supply,
  output logic listen_online_select,
  output cplc_pkg::cplc_timeout_t offline_timeout,
  output logic transmitter_enable,
  output logic active_state_grant,
  output logic [15:0] can_phy_control_readback
);

  ////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [2:0] pins_s;
  logic sck_s;
  logic sdi_s;
  logic csn_s;

  cplc_sync u_sync (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .pin_in({spi_csn, spi_sdi, spi_sck}),
    .stable_out(pins_s)
  );

  assign sck_s = pins_s[0];
  assign sdi_s = pins_s[1];
  assign csn_s = pins_s[2];

  logic [1:0] loop_pins_meta_r;
  logic [1:0] loop_pins_mid_r;
  logic [1:0] loop_pins_last_r;
  logic txd_s_r;
  logic txd_s_nxt;
  logic busrxd_s_r;
  logic busrxd_s_nxt;

  always_comb begin
    txd_s_nxt = (loop_pins_mid_r[0] == loop_pins_last_r[0]) ? loop_pins_last_r[0] : txd_s_r;
    busrxd_s_nxt = (loop_pins_mid_r[1] == loop_pins_last_r[1]) ? loop_pins_last_r[1] : busrxd_s_r;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loop_pins_meta_r <= cplc_pkg::LOOP_SYNC_RESET;
      loop_pins_mid_r <= cplc_pkg::LOOP_SYNC_RESET;
      loop_pins_last_r <= cplc_pkg::LOOP_SYNC_RESET;
      txd_s_r <= 1'b1;
      busrxd_s_r <= 1'b1;
    end else if (ce) begin
      loop_pins_meta_r <= {can_bus_rxd, can_txd_in};
      loop_pins_mid_r <= loop_pins_meta_r;
      loop_pins_last_r <= loop_pins_mid_r;
      txd_s_r <= txd_s_nxt;
      busrxd_s_r <= busrxd_s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Serial frame engine
  cplc_pkg::cplc_frame_t state_r;
  cplc_pkg::cplc_frame_t state_nxt;
  logic sck_d_r;
  logic [15:0] rx_r;
  logic [15:0] rx_nxt;
  logic [15:0] tx_r;
  logic [15:0] tx_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic oe_r;
  logic oe_nxt;
  logic sck_rise;
  logic sck_fall;
  logic frame_end;
  logic load_reply;
  logic commit_write;
  logic [15:0] reply_word;

  assign sck_rise = sck_s && !sck_d_r;
  assign sck_fall = !sck_s && sck_d_r;
  assign frame_end = (state_r == cplc_pkg::CPLC_SHIFT) && csn_s;
  assign load_reply = sck_rise && (cnt_r == cplc_pkg::SELECT_BITS - 5'h01);
  assign commit_write = frame_end && (cnt_r == cplc_pkg::FULL_FRAME)
    && (rx_r[cplc_pkg::ADDR_HI:cplc_pkg::ADDR_LO] == cplc_pkg::PHY_CTRL_ADDR)
    && !rx_r[cplc_pkg::NOWRITE_POS];

  always_comb begin
    if (sdi_s) begin
      reply_word = {3'h0, gp_feedback_one[12:0]};
    end else begin
      reply_word = {3'h0, can_phy_control_readback[12:0]};
    end
  end

  always_comb begin
    state_nxt = state_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    cnt_nxt = cnt_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    unique case (state_r)
      cplc_pkg::CPLC_IDLE: begin
        if (!csn_s) begin
          state_nxt = cplc_pkg::CPLC_SHIFT;
          cnt_nxt = 5'h00;
          rx_nxt = cplc_pkg::WORD_RESET;
          tx_nxt = cplc_pkg::WORD_RESET;
          sdo_nxt = 1'b0;
          oe_nxt = 1'b0;
        end
      end
      cplc_pkg::CPLC_SHIFT: begin
        if (csn_s) begin
          state_nxt = cplc_pkg::CPLC_IDLE;
          oe_nxt = 1'b0;
          sdo_nxt = 1'b0;
        end else if (sck_rise) begin
          rx_nxt = {rx_r[14:0], sdi_s};
          if (cnt_r != cplc_pkg::COUNT_MAX) begin
            cnt_nxt = cnt_r + 5'h01;
          end
          // Reply only when this register is addressed
          if (load_reply && (rx_r[1:0] == cplc_pkg::PHY_CTRL_ADDR)) begin
            tx_nxt = reply_word << cplc_pkg::SELECT_BITS;
            oe_nxt = 1'b1;
          end
        end else if (sck_fall && oe_r) begin
          sdo_nxt = tx_r[15];
          tx_nxt = {tx_r[14:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= cplc_pkg::CPLC_IDLE;
      sck_d_r <= 1'b0;
      rx_r <= cplc_pkg::WORD_RESET;
      tx_r <= cplc_pkg::WORD_RESET;
      cnt_r <= 5'h00;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      sck_d_r <= sck_s;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      cnt_r <= cnt_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign spi_sdo = sdo_r;
  assign spi_sdo_oe = oe_r;

  ////////////////////////////////////////////////////////////
  // Control fields
  logic supply_keep_r;
  logic pn_listen_r;
  logic timeout_long_r;
  logic tx_disable_r;
  logic loopback_r;
  logic active_req_r;
  logic wake_ext_r;
  logic [5:0] fields_nxt;
  logic wake_ext_nxt;

  always_comb begin
    fields_nxt = {supply_keep_r, pn_listen_r, timeout_long_r, tx_disable_r, loopback_r, active_req_r};
    wake_ext_nxt = wake_ext_r;
    if (enter_online_normal || enter_can_active) begin
      fields_nxt[cplc_pkg::PN_POS - cplc_pkg::FIELD_LO] = 1'b0;
    end
    if (wake_event) begin
      wake_ext_nxt = 1'b1;
    end
    if (commit_write) begin
      fields_nxt = rx_r[cplc_pkg::FIELD_HI:cplc_pkg::FIELD_LO];
      wake_ext_nxt = wake_event;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {supply_keep_r, pn_listen_r, timeout_long_r, tx_disable_r, loopback_r, active_req_r} <=
        cplc_pkg::FIELDS_RESET;
      wake_ext_r <= 1'b0;
    end else if (ce) begin
      {supply_keep_r, pn_listen_r, timeout_long_r, tx_disable_r, loopback_r, active_req_r} <= fields_nxt;
      wake_ext_r <= wake_ext_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs to the transceiver
  logic supply_r;
  logic listen_r;
  cplc_pkg::cplc_timeout_t timeout_r;
  cplc_pkg::cplc_timeout_t timeout_nxt;
  logic txen_r;
  logic rxd_r;
  logic grant_r;
  logic [15:0] readback_r;
  logic supply_nxt;
  logic txen_nxt;
  logic rxd_nxt;
  logic grant_nxt;

  always_comb begin
    supply_nxt = supply_keep_r || !offline_mode;
    txen_nxt = !tx_disable_r;
    rxd_nxt = (loopback_r && tx_disable_r) ? txd_s_r : busrxd_s_r;
    grant_nxt = active_req_r && (chip_normal_mode || chip_flash_mode);
    if (wake_ext_r) begin
      timeout_nxt = cplc_pkg::CPLC_TO_EXTENDED;
    end else if (timeout_long_r) begin
      timeout_nxt = cplc_pkg::CPLC_TO_LONG;
    end else begin
      timeout_nxt = cplc_pkg::CPLC_TO_SHORT;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supply_r <= 1'b1;
      listen_r <= 1'b0;
      timeout_r <= cplc_pkg::CPLC_TO_SHORT;
      txen_r <= 1'b1;
      rxd_r <= 1'b1;
      grant_r <= 1'b0;
      readback_r <= cplc_pkg::WORD_RESET;
    end else if (ce) begin
      supply_r <= supply_nxt;
      listen_r <= pn_listen_r;
      timeout_r <= timeout_nxt;
      txen_r <= txen_nxt;
      rxd_r <= rxd_nxt;
      grant_r <= grant_nxt;
      readback_r <= {4'h0, fields_nxt, 6'h00};
    end
  end

  assign transceiver_supply = supply_r;
  assign listen_online_select = listen_r;
  assign offline_timeout = timeout_r;
  assign transmitter_enable = txen_r;
  assign can_rxd_out = rxd_r;
  assign active_state_grant = grant_r;
  assign can_phy_control_readback = readback_r;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  chk_write_commit: assert property (ce && commit_write |=>
    tx_disable_r == $past(rx_r[cplc_pkg::TXDIS_POS]) && supply_keep_r == $past(rx_r[cplc_pkg::SUPPLY_POS]))
    else $error("frame fields not stored");
  chk_readonly_hold: assert property (ce && frame_end && rx_r[cplc_pkg::NOWRITE_POS] |=>
    $stable(tx_disable_r) && $stable(loopback_r) && $stable(active_req_r))
    else $error("read-only frame changed fields");
  chk_short_frame: assert property (ce && frame_end && cnt_r != cplc_pkg::FULL_FRAME
    |=> $stable(supply_keep_r) && $stable(timeout_long_r))
    else $error("short frame changed fields");
  chk_addr_reply: assert property (ce && load_reply && rx_r[1:0] != cplc_pkg::PHY_CTRL_ADDR
    && !oe_r |=> !spi_sdo_oe)
    else $error("reply driven for other address");
  chk_reply_source: assert property (ce && sck_rise && load_reply && rx_r[1:0] == cplc_pkg::PHY_CTRL_ADDR
    && !csn_s |=> tx_r[15:3] == $past(sdi_s ? gp_feedback_one[12:0] : readback_r[12:0]))
    else $error("wrong reply source");
  chk_tx_enable: assert property (ce && tx_disable_r ##1 ce |-> !transmitter_enable)
    else $error("transmitter enabled while disabled");
  chk_loop_path: assert property (ce && loopback_r && tx_disable_r |=> can_rxd_out == $past(txd_s_r))
    else $error("loopback not applied");
  chk_no_loop: assert property (ce && !loopback_r |=> can_rxd_out == $past(busrxd_s_r))
    else $error("loopback without request");
  chk_pn_clear: assert property (ce && enter_can_active && !commit_write |=> !pn_listen_r ##1 (!ce || !listen_online_select))
    else $error("partial networking not cleared");
  chk_active_gate: assert property (ce && !chip_normal_mode && !chip_flash_mode |=> !active_state_grant)
    else $error("active state granted outside normal or flash");
  chk_supply_off: assert property (ce && offline_mode && !supply_keep_r |=> !transceiver_supply)
    else $error("supply kept on while off-line");

endmodule

// ### rtl/cplc_sync.sv
`timescale 1ns/100ps
module cplc_sync (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [2:0] pin_in,
  output logic [2:0] stable_out
);

  logic [2:0] meta_r;
  logic [2:0] mid_r;
  logic [2:0] last_r;
  logic [2:0] stable_r;
  logic [2:0] stable_nxt;

  ////////////////////////////////////////////////////////////
  // A change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      stable_nxt[i] = (mid_r[i] == last_r[i]) ? last_r[i] : stable_r[i];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= cplc_pkg::SPI_SYNC_RESET;
      mid_r <= cplc_pkg::SPI_SYNC_RESET;
      last_r <= cplc_pkg::SPI_SYNC_RESET;
      stable_r <= cplc_pkg::SPI_SYNC_RESET;
    end else if (ce) begin
      meta_r <= pin_in;
      mid_r <= meta_r;
      last_r <= mid_r;
      stable_r <= stable_nxt;
    end
  end

  assign stable_out = stable_r;

endmodule

// ### tb/can_phy_layer_control_regs_tb.sv
`timescale 1ns/100ps
module can_phy_layer_control_regs_tb;
  logic clock, resetn, ce, spi_sck, spi_sdi, spi_csn, spi_sdo, spi_sdo_oe;
  logic [15:0] gp_feedback_one, can_phy_control_readback;
  logic can_txd_in, can_bus_rxd, can_rxd_out, offline_mode, enter_online_normal, enter_can_active;
  logic wake_event, chip_normal_mode, chip_flash_mode;
  logic transceiver_supply, listen_online_select, transmitter_enable, active_state_grant;
  cplc_pkg::cplc_timeout_t offline_timeout;
  logic [12:0] reply;
  logic oe_hit;
  int num_errors = 0;
  int tests_run = 0;

  cplc_regs dut_u (
    .clock(clock), .resetn(resetn), .ce(ce), .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_csn(spi_csn),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .gp_feedback_one(gp_feedback_one),
    .can_txd_in(can_txd_in), .can_bus_rxd(can_bus_rxd), .can_rxd_out(can_rxd_out),
    .offline_mode(offline_mode), .enter_online_normal(enter_online_normal),
    .enter_can_active(enter_can_active), .wake_event(wake_event), .chip_normal_mode(chip_normal_mode),
    .chip_flash_mode(chip_flash_mode), .transceiver_supply(transceiver_supply),
    .listen_online_select(listen_online_select), .offline_timeout(offline_timeout),
    .transmitter_enable(transmitter_enable), .active_state_grant(active_state_grant),
    .can_phy_control_readback(can_phy_control_readback)
  );

  cplc_host_model host_u (
    .clock(clock), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_csn(spi_csn)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] fr(input logic readback_source_select, input logic ro, input logic [5:0] f);
    return {cplc_pkg::PHY_CTRL_ADDR, readback_source_select, ro, f, 6'h00};
  endfunction

  function automatic logic [15:0] rb(input logic [5:0] f);
    return {4'h0, f, 6'h00};
  endfunction

  task automatic frame(input logic [15:0] word, input int nbits);
    host_u.xfer(word, nbits, reply, oe_hit);
    step(6);
  endtask

  // 0 online normal, 1 can active, 2 wake
  task automatic pulse(input int which);
    enter_online_normal = (which == 0);
    enter_can_active = (which == 1);
    wake_event = (which == 2);
    step(1);
    {enter_online_normal, enter_can_active, wake_event} = 3'h0;
    step(4);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end

  initial begin
    {resetn, enter_online_normal, enter_can_active, wake_event, chip_normal_mode, chip_flash_mode} = 6'h00;
    {offline_mode, can_txd_in} = 2'h0;
    {ce, can_bus_rxd} = 2'h3;
    gp_feedback_one = 16'h5A5A;
    step(4);
    resetn = 1'b1;
    step(8);
    check(can_phy_control_readback, 16'h0000);
    check({15'h0000, transmitter_enable}, 16'h0001);
    check({15'h0000, transceiver_supply}, 16'h0001);
    frame(fr(1'b0, 1'b0, 6'h3F), 16);
    check({3'h0, reply}, 16'h0000);
    check(can_phy_control_readback, rb(6'h3F));
    check({15'h0000, transmitter_enable}, 16'h0000);
    check({15'h0000, listen_online_select}, 16'h0001);
    check({15'h0000, can_rxd_out}, 16'h0000);
    check({14'h0000, offline_timeout}, {14'h0000, cplc_pkg::CPLC_TO_LONG});
    check({15'h0000, active_state_grant}, 16'h0000);
    chip_normal_mode = 1'b1;
    step(4);
    check({15'h0000, active_state_grant}, 16'h0001);
    chip_normal_mode = 1'b0;
    chip_flash_mode = 1'b1;
    offline_mode = 1'b1;
    step(4);
    check({15'h0000, active_state_grant}, 16'h0001);
    check({15'h0000, transceiver_supply}, 16'h0001);
    frame(fr(1'b0, 1'b1, 6'h00), 16);
    check({3'h0, reply}, rb(6'h3F));
    check(can_phy_control_readback, rb(6'h3F));
    frame(fr(1'b1, 1'b1, 6'h00), 16);
    check({3'h0, reply}, {3'h0, gp_feedback_one[12:0]});
    frame(16'h8000, 16);
    check({15'h0000, oe_hit}, 16'h0000);
    check(can_phy_control_readback, rb(6'h3F));
    frame(fr(1'b0, 1'b0, 6'h00), 8);
    check(can_phy_control_readback, rb(6'h3F));
    pulse(0);
    check(can_phy_control_readback, rb(6'h2F));
    frame(fr(1'b0, 1'b0, 6'h3F), 16);
    pulse(1);
    check({15'h0000, listen_online_select}, 16'h0000);
    pulse(2);
    check({14'h0000, offline_timeout}, {14'h0000, cplc_pkg::CPLC_TO_EXTENDED});
    frame(fr(1'b0, 1'b0, 6'h02), 16);
    check({15'h0000, transceiver_supply}, 16'h0000);
    check({15'h0000, transmitter_enable}, 16'h0001);
    check({15'h0000, can_rxd_out}, 16'h0001);
    check({15'h0000, active_state_grant}, 16'h0000);
    check({14'h0000, offline_timeout}, {14'h0000, cplc_pkg::CPLC_TO_SHORT});
    // Clock enable low freezes frames and events
    ce = 1'b0;
    pulse(2);
    frame(fr(1'b0, 1'b0, 6'h3F), 16);
    check(can_phy_control_readback, rb(6'h02));
    check({14'h0000, offline_timeout}, {14'h0000, cplc_pkg::CPLC_TO_SHORT});
    ce = 1'b1;
    step(8);
    check(can_phy_control_readback, rb(6'h02));
    check({15'h0000, transmitter_enable}, 16'h0001);
    conclude();
  end
endmodule

// ### tb/cplc_host_model.sv
`timescale 1ns/100ps
module cplc_host_model (
  input wire logic clock,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  output logic spi_sck,
  output logic spi_sdi,
  output logic spi_csn
);
  logic oe_seen;

  initial begin
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    spi_csn = 1'b1;
    oe_seen = 1'b0;
  end

  // Released data line toggles so no stale bit lingers
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #10;
      if (spi_sdo_oe === 1'b1) oe_seen = 1'b1;
      if (spi_csn) spi_sdi = ~spi_sdi;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Frame of nbits, MSB first; reply gathered from the 4th rise
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [12:0] reply, output logic oe_hit);
    oe_seen = 1'b0;
    reply = 13'h0000;
    spi_csn = 1'b0;
    tick(8);
    for (int i = 0; i < nbits; i++) begin
      spi_sdi = word[15 - i];
      tick(8);
      spi_sck = 1'b1;
      if (i >= 3) reply = {reply[11:0], (spi_sdo_oe === 1'b1) ? spi_sdo : ~reply[0]};
      tick(8);
      spi_sck = 1'b0;
    end
    tick(8);
    spi_csn = 1'b1;
    tick(12);
    oe_hit = oe_seen;
  endtask
endmodule
